/* core/keepalive_timer.sv */
// periodic tick generator for keep-alive segments
`timescale 1ns/1ps
module keepalive_timer #(
  parameter int PERIOD = sock_cmd_pkg::KEEP_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic run,
  // tick out
  output logic      tick
);
  import sock_cmd_pkg::*;
  localparam int         CW   = $clog2(PERIOD + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  logic [CW-1:0] cnt_q;   // cycles since last tick
  logic [CW-1:0] cnt_d;
  logic          tick_q;  // registered tick
  wire           wrap = run && (cnt_q == LAST);

  // restart from zero whenever stopped, so the first tick is a full period after start
  assign cnt_d = !run ? '0 : (wrap ? '0 : cnt_q + CW'(1));

  // counter and tick flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= wrap;
    end
  end

  assign tick = tick_q;
endmodule

/* core/sock_cmd_pkg.sv */
// shared constants for the socket send command handler
package sock_cmd_pkg;
  // command codes written into the command field
  localparam logic [7:0] CMD_NONE      = 8'h00;
  localparam logic [7:0] CMD_SEND      = 8'h20;
  localparam logic [7:0] CMD_SEND_HW   = 8'h21;
  localparam logic [7:0] CMD_SEND_KEEP = 8'h22;
  // protocol mode codes
  localparam logic [3:0] MODE_CLOSED   = 4'h0;
  localparam logic [3:0] MODE_TCP      = 4'h1;
  localparam logic [3:0] MODE_UDP      = 4'h2;
  localparam logic [3:0] MODE_RAW_IP   = 4'h3;
  localparam logic [3:0] MODE_RAW_FRM  = 4'h4;
  // socket state code forced on timeout, and the reset value
  localparam logic [7:0] STATE_CLOSED  = 8'h00;
  localparam logic [7:0] STATE_RESET   = 8'h00;
  // interrupt flag positions and reset value
  localparam int         FLAG_SEND_DONE = 4;
  localparam int         FLAG_TIMEOUT   = 3;
  localparam logic [7:0] FLAGS_RESET    = 8'h00;
  // buffer and timing defaults
  localparam int         FREE_W         = 16;
  localparam logic [15:0] TX_BUF_BYTES  = 16'h0800;
  localparam int         KEEP_CYCLES    = 1000;
  // send sequencer states
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_RESOLVE  = 3'b001,
    ST_XMIT     = 3'b010,
    ST_CREDIT   = 3'b011,
    ST_WAIT_ACK = 3'b100
  } send_state_t;
endpackage

/* core/socket_send_command_handler.sv */
// per-socket send command handler: send, send to known hw address, keep-alive
`timescale 1ns/1ps
module socket_send_command_handler #(
  parameter int KEEP_PERIOD = sock_cmd_pkg::KEEP_CYCLES,
  parameter logic [15:0] TX_BUF = sock_cmd_pkg::TX_BUF_BYTES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // host command field
  input  wire logic        cmd_wr,
  input  wire logic [7:0]  cmd_wdata,
  output logic      [7:0]  cmd_field,
  // socket configuration
  input  wire logic [3:0]  proto_mode,
  input  wire logic [15:0] tx_len,
  input  wire logic [47:0] dest_hw_addr,
  // socket state, loaded by the rest of the controller
  input  wire logic        state_load,
  input  wire logic [7:0]  state_wdata,
  output logic      [7:0]  socket_state,
  // interrupt flags, write one to clear
  input  wire logic [7:0]  flags_clr,
  output logic      [7:0]  socket_interrupt_flags,
  // free size counter
  output logic      [15:0] tx_free_size,
  // protocol engine side
  output logic             resolve_req,
  input  wire logic        resolve_done,
  output logic             xmit_req,
  output logic      [47:0] xmit_hw_addr,
  output logic      [15:0] xmit_len,
  input  wire logic        xmit_done,
  input  wire logic        peer_ack,
  input  wire logic        ack_timeout,
  output logic             keepalive_active,
  output logic             keepalive_req
);
  import sock_cmd_pkg::*;

  // state
  send_state_t st_q, st_d;        // send sequencer
  logic [7:0]  cmd_q;             // visible command field
  logic [7:0]  flags_q;           // sticky interrupt flags
  logic [7:0]  sock_st_q;         // socket state
  logic [15:0] free_q;            // transmit free size
  logic [15:0] len_q;             // bytes of the send in flight
  logic [47:0] hw_q;              // hw address captured at accept
  logic        keep_q;            // keep-alive running
  logic        keep_tick;         // period tick

  // saturating add, used by both credit paths
  function automatic logic [15:0] credit(input logic [15:0] f, input logic [15:0] n, input logic [15:0] lim);
    logic [16:0] s;
    s = {1'b0, f} + {1'b0, n};
    credit = (s > {1'b0, lim}) ? lim : s[15:0];
  endfunction

  // mode decode
  wire is_tcp    = (proto_mode == MODE_TCP);
  wire is_udp    = (proto_mode == MODE_UDP);
  wire is_raw_ip = (proto_mode == MODE_RAW_IP);
  wire is_raw_fr = (proto_mode == MODE_RAW_FRM);
  wire has_cmd   = (cmd_q != CMD_NONE);
  wire idle      = (st_q == ST_IDLE);

  // command decode; send commands in the wrong mode or while busy are dropped, keep-alive only in the wrong mode
  wire acc_send = has_cmd && idle && (cmd_q == CMD_SEND) && (is_tcp || is_udp || is_raw_ip || is_raw_fr);
  wire acc_hw   = has_cmd && idle && (cmd_q == CMD_SEND_HW) && (is_udp || is_raw_ip);
  wire acc_keep = has_cmd && (cmd_q == CMD_SEND_KEEP) && is_tcp;
  wire acc_any  = acc_send || acc_hw;

  // completion events inside the sequencer
  wire done_evt  = (st_q == ST_XMIT) && xmit_done;
  wire ack_evt   = (st_q == ST_WAIT_ACK) && peer_ack && !ack_timeout;
  wire to_evt    = (st_q == ST_WAIT_ACK) && ack_timeout;
  wire credit_ev = (st_q == ST_CREDIT) || ack_evt;
  wire [15:0] credit_sum = credit(free_q, len_q, TX_BUF);
  wire [15:0] debit_val  = (tx_len > free_q) ? 16'h0000 : (free_q - tx_len);

  // sequencer next state
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (acc_hw) begin
          st_d = ST_XMIT;
        end else if (acc_send) begin
          st_d = is_raw_fr ? ST_XMIT : ST_RESOLVE;
        end
      end
      ST_RESOLVE: begin
        if (resolve_done) begin
          st_d = ST_XMIT;
        end
      end
      ST_XMIT: begin
        if (xmit_done) begin
          st_d = is_tcp ? ST_WAIT_ACK : ST_CREDIT;
        end
      end
      ST_CREDIT: begin
        st_d = ST_IDLE;
      end
      ST_WAIT_ACK: begin
        if (peer_ack || ack_timeout) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // sequencer and send context
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= ST_IDLE;
      len_q <= 16'h0000;
      hw_q  <= 48'h000000000000;
    end else begin
      st_q <= st_d;
      if (acc_any) begin
        len_q <= tx_len;
        hw_q  <= dest_hw_addr;
      end
    end
  end

  // command field: host write lands, then clears the cycle after decode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= CMD_NONE;
    end else if (cmd_wr) begin
      cmd_q <= cmd_wdata;
    end else if (has_cmd) begin
      cmd_q <= CMD_NONE;
    end
  end

  // sticky flags; a set in the same cycle as a clear wins
  wire [7:0] flag_set = ({7'h00, done_evt} << FLAG_SEND_DONE) | ({7'h00, to_evt} << FLAG_TIMEOUT);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= FLAGS_RESET;
    end else begin
      flags_q <= (flags_q & ~flags_clr) | flag_set;
    end
  end

  // socket state; timeout forces closed over any load
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sock_st_q <= STATE_RESET;
    end else if (to_evt) begin
      sock_st_q <= STATE_CLOSED;
    end else if (state_load) begin
      sock_st_q <= state_wdata;
    end
  end

  // free size: debit at accept, credit after done flag or on ack
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      free_q <= TX_BUF;
    end else if (acc_any) begin
      free_q <= debit_val;
    end else if (credit_ev) begin
      free_q <= credit_sum;
    end
  end

  // keep-alive run bit; stops when the socket leaves tcp or times out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      keep_q <= 1'b0;
    end else if (to_evt || !is_tcp) begin
      keep_q <= 1'b0;
    end else if (acc_keep) begin
      keep_q <= 1'b1;
    end
  end

  // period source for repeated keep-alive segments
  keepalive_timer #(
    .PERIOD (KEEP_PERIOD)
  ) u_keep (
    .clk   (clk),
    .rst_n (rst_n),
    .run   (keep_q),
    .tick  (keep_tick)
  );

  // outputs
  assign cmd_field              = cmd_q;
  assign socket_state           = sock_st_q;
  assign socket_interrupt_flags = flags_q;
  assign tx_free_size           = free_q;
  assign resolve_req            = (st_q == ST_RESOLVE);
  assign xmit_req               = (st_q == ST_XMIT);
  assign xmit_hw_addr           = hw_q;
  assign xmit_len               = len_q;
  assign keepalive_active       = keep_q;
  assign keepalive_req          = keep_q && keep_tick;

  // cycles since the last keep-alive pulse, only read by the repeat check
  localparam int GW = $clog2(KEEP_PERIOD + 2);
  logic [GW-1:0] gap_q;           // restarts on every pulse or while stopped

  // gap counter; wide enough to reach KEEP_PERIOD + 1 so a missing pulse shows before it wraps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= '0;
    end else if (!keep_q || keepalive_req) begin
      gap_q <= '0;
    end else begin
      gap_q <= gap_q + GW'(1);
    end
  end

  // checks
  sequence s_raw_done;
    (st_q == ST_XMIT) && xmit_done && !is_tcp;
  endsequence
  sequence s_flag_then_credit;
    flags_q[FLAG_SEND_DONE] && (st_q == ST_CREDIT);
  endsequence

  chk_credit_after_done: assert property (@(posedge clk) disable iff (!rst_n)
    s_raw_done |=> s_flag_then_credit ##1 (free_q == $past(credit_sum)))
    else $error("free size not credited after send done");
  chk_timeout_closes: assert property (@(posedge clk) disable iff (!rst_n)
    to_evt |=> (flags_q[FLAG_TIMEOUT] && (sock_st_q == STATE_CLOSED) && (st_q == ST_IDLE)))
    else $error("timeout did not close socket");
  chk_ack_credit: assert property (@(posedge clk) disable iff (!rst_n)
    ack_evt |=> (free_q == $past(credit_sum))
    && (flags_q[FLAG_TIMEOUT] == $past(flags_q[FLAG_TIMEOUT] && !flags_clr[FLAG_TIMEOUT])))
    else $error("ack did not credit free size");
  chk_hw_mode_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (has_cmd && idle && (cmd_q == CMD_SEND_HW) && !(is_udp || is_raw_ip)) |=> (st_q == ST_IDLE))
    else $error("known hw send accepted in wrong mode");
  chk_hw_skip_resolve: assert property (@(posedge clk) disable iff (!rst_n)
    acc_hw |=> (st_q == ST_XMIT) && !resolve_req && (xmit_hw_addr == $past(dest_hw_addr)))
    else $error("known hw send did not skip resolution");
  chk_keep_mode_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (has_cmd && (cmd_q == CMD_SEND_KEEP) && !to_evt) |=> (keep_q == $past(is_tcp)))
    else $error("keep-alive gate wrong");
  chk_keep_repeat: assert property (@(posedge clk) disable iff (!rst_n)
    keep_q |-> (gap_q <= GW'(KEEP_PERIOD)))
    else $error("keep-alive segments not repeating");
  chk_cmd_clear: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_wr ##1 !cmd_wr |=> (cmd_q == CMD_NONE))
    else $error("command field not cleared");
endmodule

/* tb/test_socket_send_command_handler.sv */
// self-checking bench for the socket send command handler
`timescale 1ns/1ps
module test_socket_send_command_handler;
  import sock_cmd_pkg::*;
  localparam int KP = 16;                       // short keep-alive period keeps the run brief
  typedef struct {int s; logic [47:0] v;} note_t;
  // design inputs
  logic        clk, rst_n, cmd_wr, state_load, resolve_done, xmit_done, peer_ack, ack_timeout;
  logic [7:0]  cmd_wdata, state_wdata, flags_clr;
  logic [3:0]  proto_mode;
  logic [15:0] tx_len;
  logic [47:0] dest_hw_addr;
  // design outputs
  logic [7:0]  cmd_field, socket_state, socket_interrupt_flags;
  logic [15:0] tx_free_size, xmit_len;
  logic [47:0] xmit_hw_addr;
  logic        resolve_req, xmit_req, keepalive_active, keepalive_req;
  // bookkeeping
  note_t       notes[$];                        // expected results, oldest first
  int          n_fail, comparisons;
  socket_send_command_handler #(.KEEP_PERIOD(KP), .TX_BUF(TX_BUF_BYTES)) i_dut (
    .clk(clk), .rst_n(rst_n), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata), .cmd_field(cmd_field),
    .proto_mode(proto_mode), .tx_len(tx_len), .dest_hw_addr(dest_hw_addr), .state_load(state_load),
    .state_wdata(state_wdata), .socket_state(socket_state), .flags_clr(flags_clr),
    .socket_interrupt_flags(socket_interrupt_flags), .tx_free_size(tx_free_size),
    .resolve_req(resolve_req), .resolve_done(resolve_done), .xmit_req(xmit_req),
    .xmit_hw_addr(xmit_hw_addr), .xmit_len(xmit_len), .xmit_done(xmit_done), .peer_ack(peer_ack),
    .ack_timeout(ack_timeout), .keepalive_active(keepalive_active), .keepalive_req(keepalive_req));
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // output selected by a note
  function automatic logic [47:0] probe(input int s);
    case (s)
      0: return 48'(cmd_field);
      1: return 48'(socket_interrupt_flags);
      2: return 48'(socket_state);
      3: return 48'(tx_free_size);
      4: return 48'(resolve_req);
      5: return 48'(xmit_req);
      6: return xmit_hw_addr;
      7: return 48'(xmit_len);
      8: return 48'(keepalive_active);
      default: return 48'(keepalive_req);
    endcase
  endfunction
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp, input int s);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t probe %0d got %h expected %h", $time, s, got, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watcher: settles every pending note at the next rising edge, before that edge's updates land
  always @(posedge clk) begin : watch
    note_t n;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      cmp(probe(n.s), n.v, n.s);
    end
  end
  task automatic nx();
    @(negedge clk);
  endtask
  task automatic want(input int s, input logic [47:0] v);
    notes.push_back('{s, v});
  endtask
  // bounded wait on an output, a miss ends the run
  task automatic wait_for(input int s, input logic [47:0] v);
    for (int i = 0; i < 64 && probe(s) !== v; i++) nx();
    if (probe(s) !== v) begin
      n_fail++;
      $display("[FAIL] %0t wait on probe %0d ran out", $time, s);
      final_report();
    end
  endtask
  task automatic issue(input logic [7:0] c);
    cmd_wr = 1'b1;
    cmd_wdata = c;
    nx();
    cmd_wr = 1'b0;
  endtask
  // send in the given mode (closed and tcp included), ok tells whether it must be taken
  task automatic run_send(input logic [3:0] m, input logic [7:0] c, input bit ok);
    logic [15:0] len;
    len = 16'($urandom_range(1, 2047));
    dest_hw_addr = {16'($urandom), $urandom};
    tx_len = len;
    proto_mode = m;
    nx();
    issue(c);
    want(0, 48'(c));
    nx();
    want(0, 48'h0);
    want(4, 48'h0);
    want(5, 48'(ok));
    if (ok) begin
      want(3, 48'(16'h0800 - len));
      want(6, dest_hw_addr);
      want(7, 48'(len));
      xmit_done = 1'b1;
      nx();
      xmit_done = 1'b0;
      want(1, 48'h10);
      want(3, 48'(16'h0800 - len));
      nx();
      want(3, 48'h0800);
      flags_clr = 8'h10;
      nx();
      flags_clr = 8'h00;
    end
    nx();
  endtask
  // ordinary tcp send, ended by a peer ack or by a timeout
  task automatic tcp_send(input bit fail);
    logic [15:0] len;
    len = 16'($urandom_range(1, 2047));
    tx_len = len;
    proto_mode = MODE_TCP;
    issue(CMD_SEND);
    nx();
    want(4, 48'h1);
    want(5, 48'h0);
    resolve_done = 1'b1;
    nx();
    resolve_done = 1'b0;
    wait_for(5, 48'h1);
    xmit_done = 1'b1;
    nx();
    xmit_done = 1'b0;
    want(3, 48'(16'h0800 - len));
    ack_timeout = fail;
    peer_ack = !fail;
    nx();
    ack_timeout = 1'b0;
    peer_ack = 1'b0;
    want(3, fail ? 48'(16'h0800 - len) : 48'h0800);
    if (fail) begin
      want(1, 48'h18);
      want(2, 48'(STATE_CLOSED));
    end
    nx();
    flags_clr = 8'hFF;
    nx();
    flags_clr = 8'h00;
  endtask
  initial begin
    cmd_wr = 1'b0;
    cmd_wdata = 8'h00;
    state_load = 1'b0;
    state_wdata = 8'h00;
    flags_clr = 8'h00;
    proto_mode = MODE_UDP;
    tx_len = 16'h0000;
    dest_hw_addr = 48'h000000000000;
    resolve_done = 1'b0;
    xmit_done = 1'b0;
    peer_ack = 1'b0;
    ack_timeout = 1'b0;
    n_fail = 0;
    comparisons = 0;
    rst_n = 1'b0;
    void'($urandom(78371));
    repeat (9) nx();
    rst_n = 1'b1;
    want(0, 48'h0);
    want(1, 48'h0);
    want(2, 48'(STATE_RESET));
    want(3, 48'h0800);
    nx();
    $display("test reset values done");
    for (int m = 0; m < 5; m++) run_send(4'(m), CMD_SEND_HW, 4'(m) == MODE_UDP || 4'(m) == MODE_RAW_IP);
    run_send(MODE_CLOSED, CMD_SEND, 1'b0);  // plain send refused while closed
    run_send(MODE_RAW_FRM, CMD_SEND, 1'b1);
    $display("test datagram sends done");
    tcp_send(1'b0);                 // data sent before keep-alive
    $display("test tcp ack done");
    proto_mode = MODE_UDP;
    issue(CMD_SEND_KEEP);
    nx();
    want(8, 48'h0);
    proto_mode = MODE_TCP;
    issue(CMD_SEND_KEEP);
    nx();
    want(8, 48'h1);
    wait_for(9, 48'h1);
    repeat (15) nx();
    want(9, 48'h0);
    nx();
    want(9, 48'h1);
    proto_mode = MODE_UDP;
    repeat (2) nx();
    want(8, 48'h0);
    $display("test keep-alive done");
    state_load = 1'b1;
    state_wdata = 8'h17;
    nx();
    state_load = 1'b0;
    want(2, 48'h17);
    tcp_send(1'b1);
    $display("test tcp timeout done");
    nx();
    final_report();
  end
  // hang guard
  initial begin
    #100us;
    n_fail++;
    $display("[FAIL] %0t run limit reached", $time);
    final_report();
  end
endmodule
